// file: hdl/baseband_irq_ctrl.sv
// Baseband interrupt status, masking and PHY control for one core
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
module baseband_irq_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register port
   input wire baseband_pkg::bus_req_t bus,
   output logic [baseband_pkg::DATA_W-1:0] rdata,
   // Datapath events
   input wire baseband_pkg::rx_evt_t rx,
   input wire baseband_pkg::tx_evt_t tx,
   // Control outputs
   output baseband_pkg::ctrl_out_t ctrl,
   output logic irq
);
   import baseband_pkg::*;

   state_t s_r;
   state_t s_nxt;
   logic [DATA_W-1:0] set_v;
   logic en;
   logic cancel;
   logic live;
   logic rx_ok;
   logic [LEN_W-1:0] fcs_len;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      set_v = '0;
      en = s_r.ctrl.core_en;
      cancel = rx.discont || rx.no_header;
      live = en && (s_r.phase == RX_BUSY) && !cancel;
      rx_ok = 1'b0;
      fcs_len = s_r.pc[PC_FCS_TYPE_SELECT] ? FCS16_LEN : FCS32_LEN;
      s_nxt.ctrl.to_tx_prepare = 1'b0;
      s_nxt.ctrl.rx_restart = 1'b0;

      // Frame start
      if (en && rx.frame_start) begin
         s_nxt.phase = RX_BUSY;
         s_nxt.pc[PC_FCS_VALID_STATUS] = 1'b0;
         s_nxt.count = LEN_ZERO;
      end

      // Cancel
      if (en && (s_r.phase == RX_BUSY) && cancel) begin
         s_nxt.phase = RX_CANCELLED;
      end

      // Header
      if (live && rx.hdr_valid) begin
         set_v[ST_HDR] = 1'b1;
         s_nxt.rx_len = rx.hdr_len;
      end

      // MAC header parsed
      if (live && rx.addr_filt_en && rx.mac_done) begin
         set_v[ST_EXT] = rx.extended;
         set_v[ST_MATCH] = rx.matched;
      end

      // Octets stored
      if (live && rx.octet) begin
         s_nxt.count = s_r.count + LEN_ONE;
         if (s_nxt.count == s_r.thr) begin
            set_v[ST_LEVEL] = 1'b1;
         end
      end

      // Frame end
      if (live && rx.frame_end) begin
         s_nxt.pc[PC_FCS_VALID_STATUS] = rx.fcs_ok;
         s_nxt.phase = RX_IDLE;
         rx_ok = rx.level1_pass && (!rx.addr_filt_en || rx.matched);
         if (s_r.pc[PC_FCS_FILTER_ENABLE] && !rx.fcs_ok) begin
            rx_ok = 1'b0;
         end
         if (rx_ok) begin
            set_v[ST_RXEND] = 1'b1;
            s_nxt.ctrl.to_tx_prepare = 1'b1;
         end
      end

      // Gain control
      if (en && (s_r.phase != RX_CANCELLED) && rx.preamble) begin
         set_v[ST_HOLD] = 1'b1;
         s_nxt.ctrl.agc_hold = 1'b1;
         s_nxt.ctrl.agc_release = 1'b0;
      end
      if (en && rx.stop) begin
         set_v[ST_HOLD] = 1'b0;
         set_v[ST_REL] = 1'b1;
         s_nxt.ctrl.agc_hold = 1'b0;
         s_nxt.ctrl.agc_release = 1'b1;
         if (s_r.phase != RX_IDLE) begin
            s_nxt.phase = RX_IDLE;
            s_nxt.ctrl.rx_restart = 1'b1;
         end
      end

      // Transmit
      if (en && tx.done) begin
         set_v[ST_TXEND] = 1'b1;
      end
      s_nxt.ctrl.fcs_insert = en && s_r.pc[PC_AFCS] && (tx.remaining != LEN_ZERO)
         && (tx.remaining <= fcs_len);

      // Status: read clears, events set and win
      if (bus.rd && (bus.addr == ADDR_STATUS)) begin
         s_nxt.status = '0;
      end
      if (set_v[ST_HOLD]) begin
         s_nxt.status[ST_REL] = 1'b0;
      end
      if (set_v[ST_REL]) begin
         s_nxt.status[ST_HOLD] = 1'b0;
      end
      s_nxt.status = s_nxt.status | set_v;

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_MASK: begin
               s_nxt.mask = bus.wdata;
            end
            ADDR_PC: begin
               s_nxt.pc = (bus.wdata & ~PC_RO_MASK) | (s_nxt.pc & PC_RO_MASK);
            end
            ADDR_THR_LO: begin
               s_nxt.thr[7:0] = bus.wdata;
            end
            ADDR_THR_HI: begin
               s_nxt.thr[LEN_W-1:8] = bus.wdata[LEN_W-9:0];
            end
            default: begin
            end
         endcase
      end

      // Register reads
      s_nxt.rdata = '0;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_STATUS: s_nxt.rdata = s_r.status;
            ADDR_MASK: s_nxt.rdata = s_r.mask;
            ADDR_PC: s_nxt.rdata = s_r.pc;
            ADDR_LEN_LO: s_nxt.rdata = s_r.rx_len[7:0];
            ADDR_LEN_HI: s_nxt.rdata = {5'h00, s_r.rx_len[LEN_W-1:8]};
            ADDR_THR_LO: s_nxt.rdata = s_r.thr[7:0];
            ADDR_THR_HI: s_nxt.rdata = {5'h00, s_r.thr[LEN_W-1:8]};
            default: s_nxt.rdata = '0;
         endcase
      end

      // Control decode
      s_nxt.ctrl.core_en = s_nxt.pc[PC_CORE_ENABLE] && (s_nxt.pc[PC_PT_HI:PC_PT_LO] != PT_OFF);
      s_nxt.ctrl.phy_type = s_nxt.pc[PC_PT_HI:PC_PT_LO];
      s_nxt.ctrl.cont_tx = s_nxt.pc[PC_CTX];
      s_nxt.ctrl.fcs_filter = s_nxt.pc[PC_FCS_FILTER_ENABLE];
      s_nxt.ctrl.fcs_type = s_nxt.pc[PC_FCS_TYPE_SELECT];
      if (!s_nxt.ctrl.core_en) begin
         s_nxt.phase = RX_IDLE;
      end
      s_nxt.irq = |(s_nxt.status & s_nxt.mask);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.pc <= PC_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign ctrl = s_r.ctrl;
   assign irq = s_r.irq;

endmodule

// file: hdl/baseband_pkg.sv
// Constants, types and register map of the baseband interrupt and PHY control block
package baseband_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LEN_W = 11;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_PC = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_LEN_LO = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_LEN_HI = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_THR_LO = 8'h05;
   localparam logic [ADDR_W-1:0] ADDR_THR_HI = 8'h06;

   // ----------------------------------------
   // Status and mask bit positions
   // ----------------------------------------
   localparam int ST_HDR = 0;
   localparam int ST_RXEND = 1;
   localparam int ST_EXT = 2;
   localparam int ST_MATCH = 3;
   localparam int ST_TXEND = 4;
   localparam int ST_HOLD = 5;
   localparam int ST_REL = 6;
   localparam int ST_LEVEL = 7;

   // ----------------------------------------
   // PHY control fields and reset values
   // ----------------------------------------
   localparam int PC_CTX = 7;
   localparam int PC_FCS_FILTER_ENABLE = 6;
   localparam int PC_FCS_VALID_STATUS = 5;
   localparam int PC_AFCS = 4;
   localparam int PC_FCS_TYPE_SELECT = 3;
   localparam int PC_CORE_ENABLE = 2;
   localparam int PC_PT_HI = 1;
   localparam int PC_PT_LO = 0;
   localparam logic [DATA_W-1:0] PC_RESET = 8'h40;
   localparam logic [DATA_W-1:0] PC_RO_MASK = 8'h20;
   localparam logic [1:0] PT_OFF = 2'h0;
   localparam logic [LEN_W-1:0] FCS32_LEN = 11'h004;
   localparam logic [LEN_W-1:0] FCS16_LEN = 11'h002;
   localparam logic [LEN_W-1:0] LEN_ONE = 11'h001;
   localparam logic [LEN_W-1:0] LEN_ZERO = 11'h000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {RX_IDLE, RX_BUSY, RX_CANCELLED} rx_phase_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic frame_start;
      logic hdr_valid;
      logic [LEN_W-1:0] hdr_len;
      logic preamble;
      logic discont;
      logic no_header;
      logic mac_done;
      logic extended;
      logic matched;
      logic addr_filt_en;
      logic frame_end;
      logic fcs_ok;
      logic level1_pass;
      logic octet;
      logic stop;
   } rx_evt_t;

   typedef struct packed {
      logic done;
      logic [LEN_W-1:0] remaining;
   } tx_evt_t;

   typedef struct packed {
      logic core_en;
      logic [1:0] phy_type;
      logic cont_tx;
      logic fcs_filter;
      logic fcs_type;
      logic fcs_insert;
      logic agc_hold;
      logic agc_release;
      logic to_tx_prepare;
      logic rx_restart;
   } ctrl_out_t;

   typedef struct packed {
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] pc;
      logic [LEN_W-1:0] rx_len;
      logic [LEN_W-1:0] thr;
      logic [LEN_W-1:0] count;
      rx_phase_t phase;
      logic [DATA_W-1:0] rdata;
      logic irq;
      ctrl_out_t ctrl;
   } state_t;

endpackage

// file: sim/baseband_irq_ctrl_chk.sv
// Assertion checker for the baseband interrupt and PHY control block
`timescale 1ns/100ps
module baseband_irq_ctrl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire baseband_pkg::bus_req_t bus,
   input wire logic [baseband_pkg::DATA_W-1:0] rdata,
   input wire baseband_pkg::rx_evt_t rx,
   input wire baseband_pkg::tx_evt_t tx,
   input wire baseband_pkg::ctrl_out_t ctrl,
   input wire logic irq
);
   import baseband_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_excl; !(ctrl.agc_hold && ctrl.agc_release); endproperty
   a_excl: assert property (p_excl) else $error("hold and release both high");
   property p_hold; $rose(ctrl.agc_hold) |-> $past(rx.preamble) && !$past(rx.stop); endproperty
   a_hold: assert property (p_hold) else $error("gain hold without preamble");
   property p_rel; $rose(ctrl.agc_release) |-> $past(rx.stop); endproperty
   a_rel: assert property (p_rel) else $error("gain release without stop");
   property p_prep;
      ctrl.to_tx_prepare |-> $past(rx.frame_end && rx.level1_pass && ctrl.core_en) ##1 !ctrl.to_tx_prepare;
   endproperty
   a_prep: assert property (p_prep) else $error("bad transmit prepare pulse");
   property p_restart; ctrl.rx_restart |-> $past(rx.stop); endproperty
   a_restart: assert property (p_restart) else $error("restart without stop");
   property p_ins;
      ctrl.fcs_insert |-> $past(tx.remaining) != LEN_ZERO &&
         $past(tx.remaining) <= ($past(ctrl.fcs_type) ? FCS16_LEN : FCS32_LEN);
   endproperty
   a_ins: assert property (p_ins) else $error("checksum insert outside tail");
   property p_en; ctrl.core_en |-> ctrl.phy_type != PT_OFF; endproperty
   a_en: assert property (p_en) else $error("core on with phy off");
   property p_mask; bus.wr && bus.addr == ADDR_MASK && bus.wdata == 8'h00 |=> !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq with all masked");
   c_prep: cover property (ctrl.to_tx_prepare);
   c_ins: cover property (ctrl.fcs_insert);
   c_restart: cover property (ctrl.rx_restart);
endmodule
bind baseband_irq_ctrl baseband_irq_ctrl_chk chk_u (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
   .rx(rx), .tx(tx), .ctrl(ctrl), .irq(irq));

// file: sim/host_model.sv
// Host software model driving the register port
`timescale 1ns/100ps
module host_model (
   // Clock
   input wire logic clk,
   // Register port
   output baseband_pkg::bus_req_t bus,
   input wire logic [baseband_pkg::DATA_W-1:0] rdata
);
   import baseband_pkg::*;
   initial bus = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      d = rdata;
   endtask
   // Configure with the radio switched off first
   task automatic cfg(input logic [7:0] pc, input logic [10:0] len);
      logic [7:0] v;
      v = pc;
      if (len <= (pc[PC_FCS_TYPE_SELECT] ? FCS16_LEN : FCS32_LEN)) v[PC_AFCS] = 1'b0;
      wr(ADDR_PC, 8'h40);
      wr(ADDR_PC, v);
   endtask
endmodule

// file: sim/baseband_irq_ctrl_tb.sv
// Self-checking testbench for the baseband interrupt and PHY control block
`timescale 1ns/100ps
module baseband_irq_ctrl_tb;
   import baseband_pkg::*;
   logic clk;
   logic srst;
   bus_req_t bus;
   logic [DATA_W-1:0] rdata;
   rx_evt_t rx;
   tx_evt_t tx;
   ctrl_out_t ctrl;
   logic irq;
   int n_mismatch = 0;
   int n_checks = 0;
   baseband_irq_ctrl dut_u (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .rx(rx), .tx(tx),
      .ctrl(ctrl), .irq(irq));
   host_model host_u (.clk(clk), .bus(bus), .rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic step(input rx_evt_t v);
      rx <= v;
      @(posedge clk);
      rx <= '0;
      @(posedge clk);
   endtask
   task automatic frame(input rx_evt_t e1, input rx_evt_t e2, input logic rst, input logic [7:0] exp);
      logic [7:0] d;
      step('{frame_start:1'b1, default:'0});
      step(e1);
      step(e2);
      step('{stop:1'b1, default:'0});
      chk8({7'h0, ctrl.rx_restart}, {7'h0, rst});
      host_u.rd(ADDR_STATUS, d);
      chk8(d, exp);
   endtask
   task automatic ins(input logic [7:0] pc, input logic [10:0] rem, input logic [7:0] exp);
      host_u.cfg(pc, 11'h010);
      tx <= '{done:1'b0, remaining:rem};
      @(posedge clk);
      @(posedge clk);
      chk8({7'h0, ctrl.fcs_insert}, exp);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      host_u.rd(ADDR_PC, d);
      chk8(d, 8'h40);
      host_u.wr(ADDR_MASK, 8'h00);
      host_u.rd(8'h07, d);
      chk8(d, 8'h00);
      host_u.wr(ADDR_PC, 8'hff);
      host_u.rd(ADDR_PC, d);
      chk8(d, 8'hdf);
      chk8({5'h0, ctrl.cont_tx, ctrl.fcs_filter, ctrl.fcs_type}, 8'h07);
   endtask
   task automatic t_phy();
      for (int i = 0; i < 8; i++) begin
         host_u.cfg(8'(i), LEN_ZERO);
         chk8({5'h0, ctrl.core_en, ctrl.phy_type}, {5'h0, i[2] && i[1:0] != 2'h0, i[1:0]});
      end
   endtask
   task automatic t_rx_good();
      logic [7:0] d;
      host_u.cfg(8'h45, LEN_ZERO);
      host_u.wr(ADDR_MASK, 8'hff);
      host_u.wr(ADDR_THR_LO, 8'h03);
      step('{frame_start:1'b1, default:'0});
      step('{preamble:1'b1, default:'0});
      chk8({7'h0, ctrl.agc_hold}, 8'h01);
      step('{hdr_valid:1'b1, hdr_len:11'h123, default:'0});
      step('{mac_done:1'b1, extended:1'b1, matched:1'b1, addr_filt_en:1'b1, default:'0});
      repeat (3) step('{octet:1'b1, default:'0});
      step('{frame_end:1'b1, fcs_ok:1'b1, level1_pass:1'b1, matched:1'b1, addr_filt_en:1'b1, default:'0});
      chk8({6'h0, ctrl.to_tx_prepare, irq}, 8'h03);
      step('{stop:1'b1, default:'0});
      chk8({6'h0, ctrl.agc_hold, ctrl.agc_release}, 8'h01);
      host_u.rd(ADDR_STATUS, d);
      chk8(d, 8'hcf);
      chk8({7'h0, irq}, 8'h00);
      host_u.rd(ADDR_LEN_LO, d);
      chk8(d, 8'h23);
      host_u.rd(ADDR_LEN_HI, d);
      chk8(d, 8'h01);
      host_u.rd(ADDR_PC, d);
      chk8(d, 8'h65);
   endtask
   task automatic t_rx_bad();
      logic [7:0] d;
      host_u.cfg(8'h45, LEN_ZERO);
      frame('{frame_end:1'b1, level1_pass:1'b1, default:'0}, '0, 1'b0, 8'h40);
      frame('{discont:1'b1, default:'0}, '{hdr_valid:1'b1, default:'0}, 1'b1, 8'h40);
      frame('{no_header:1'b1, default:'0}, '{frame_end:1'b1, fcs_ok:1'b1, level1_pass:1'b1, default:'0},
         1'b1, 8'h40);
      host_u.cfg(8'h05, LEN_ZERO);
      frame('{frame_end:1'b1, level1_pass:1'b1, addr_filt_en:1'b1, default:'0}, '0, 1'b0, 8'h40);
      frame('{frame_end:1'b1, level1_pass:1'b1, default:'0}, '0, 1'b0, 8'h42);
      host_u.rd(ADDR_PC, d);
      chk8(d, 8'h05);
      // Hold after a pending release leaves only the hold flag
      step('{stop:1'b1, default:'0});
      step('{preamble:1'b1, default:'0});
      host_u.rd(ADDR_STATUS, d);
      chk8(d, 8'h20);
   endtask
   task automatic t_tx();
      logic [7:0] d;
      host_u.wr(ADDR_MASK, 8'hef);
      tx <= '{done:1'b1, remaining:LEN_ZERO};
      @(posedge clk);
      tx <= '0;
      @(posedge clk);
      chk8({7'h0, irq}, 8'h00);
      host_u.rd(ADDR_STATUS, d);
      chk8(d, 8'h10);
      ins(8'h55, 11'h004, 8'h01);
      ins(8'h55, 11'h005, 8'h00);
      ins(8'h5d, 11'h003, 8'h00);
      ins(8'h5d, 11'h002, 8'h01);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      srst = 1'b1;
      rx = '0;
      tx = '0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_phy();
      t_rx_good();
      t_rx_bad();
      t_tx();
      tally_and_finish();
   end
endmodule
